// ===== src/ahs_homing.v
// homing sequencer for one axis, methods 26 to 30 and 33 to 35
`timescale 1ns/1ps
`default_nettype none
`include "ahs_regs.vh"

module ahs_homing (
    // clock and reset
    input wire core_clk_i,
    input wire reset_i,
    // homing request
    input wire homing_request_i,
    input wire [`AHS_METHOD_W-1:0] method_i,
    input wire [`AHS_POS_W-1:0] axis_pos_i,
    // switches and encoder
    input wire home_sw_i,
    input wire pos_limit_i,
    input wire neg_limit_i,
    input wire index_i,
    // motion command
    output reg move_o,
    output reg dir_o,
    output reg speed_o,
    // result
    output reg [`AHS_POS_W-1:0] home_pos_o,
    output reg busy_o,
    output reg done_o,
    output reg error_o
);

// ----------------------------------------------------------------
// input conditioning
// ----------------------------------------------------------------
wire hs_lvl;
wire hs_rise;
wire hs_fall;
wire pl_lvl;
wire pl_rise;
wire nl_lvl;
wire nl_rise;
wire ix_rise;

ahs_sync u_sync_home (.core_clk_i(core_clk_i), .reset_i(reset_i), .pin_i(home_sw_i),
    .level_o(hs_lvl), .rise_o(hs_rise), .fall_o(hs_fall));
ahs_sync u_sync_plim (.core_clk_i(core_clk_i), .reset_i(reset_i), .pin_i(pos_limit_i),
    .level_o(pl_lvl), .rise_o(pl_rise), .fall_o());
ahs_sync u_sync_nlim (.core_clk_i(core_clk_i), .reset_i(reset_i), .pin_i(neg_limit_i),
    .level_o(nl_lvl), .rise_o(nl_rise), .fall_o());
ahs_sync u_sync_idx (.core_clk_i(core_clk_i), .reset_i(reset_i), .pin_i(index_i),
    .level_o(), .rise_o(ix_rise), .fall_o());

// a limit already on counts as a hit, not just its rising edge
wire pl_hit = pl_rise | pl_lvl;
wire nl_hit = nl_rise | nl_lvl;

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
reg [`AHS_ST_W-1:0] state_q;
reg [`AHS_METHOD_W-1:0] meth_q;
reg latch_now;
reg [`AHS_ST_W-1:0] state_d;
reg dir_d;
reg spd_d;
reg mv_d;

// seek: first leg; back: after limit reversal; fwd: final leg
always @* begin
    latch_now = 1'b0;
    state_d = state_q;
    dir_d = dir_o;
    spd_d = speed_o;
    mv_d = move_o;
    case (state_q)
        `AHS_ST_SEEK: begin
            case (meth_q)
                `AHS_M26: begin
                    if (hs_rise) begin
                        spd_d = `AHS_SPD_SECOND;
                    end else if (hs_fall) begin
                        latch_now = 1'b1;
                    end else if (pl_hit && !hs_lvl) begin
                        state_d = `AHS_ST_BACK;
                        dir_d = `AHS_DIR_NEG;
                        spd_d = `AHS_SPD_FIRST;
                    end
                end
                `AHS_M27: begin
                    if (dir_o == `AHS_DIR_POS) begin
                        if (hs_fall) begin
                            latch_now = 1'b1;
                        end
                    end else if (hs_rise) begin
                        dir_d = `AHS_DIR_POS;
                        spd_d = `AHS_SPD_SECOND;
                    end else if (nl_hit) begin
                        state_d = `AHS_ST_BACK;
                        dir_d = `AHS_DIR_POS;
                        spd_d = `AHS_SPD_FIRST;
                    end
                end
                `AHS_M28: begin
                    if (dir_o == `AHS_DIR_POS) begin
                        if (hs_fall) begin
                            state_d = `AHS_ST_FWD;
                            dir_d = `AHS_DIR_NEG;
                        end
                    end else if (hs_rise) begin
                        latch_now = 1'b1;
                    end else if (nl_hit) begin
                        state_d = `AHS_ST_BACK;
                        dir_d = `AHS_DIR_POS;
                        spd_d = `AHS_SPD_FIRST;
                    end
                end
                `AHS_M29: begin
                    if (hs_rise) begin
                        spd_d = `AHS_SPD_SECOND;
                    end else if (hs_fall) begin
                        state_d = `AHS_ST_FWD;
                        dir_d = `AHS_DIR_POS;
                    end else if (nl_hit && !hs_lvl) begin
                        state_d = `AHS_ST_FWD;
                        dir_d = `AHS_DIR_POS;
                        spd_d = `AHS_SPD_FIRST;
                    end
                end
                `AHS_M30: begin
                    if (hs_rise) begin
                        spd_d = `AHS_SPD_SECOND;
                    end else if (hs_fall) begin
                        latch_now = 1'b1;
                    end else if (nl_hit && !hs_lvl) begin
                        state_d = `AHS_ST_BACK;
                        dir_d = `AHS_DIR_POS;
                        spd_d = `AHS_SPD_FIRST;
                    end
                end
                `AHS_M33, `AHS_M34: begin
                    if (ix_rise) begin
                        latch_now = 1'b1;
                    end
                end
                default: begin
                    state_d = `AHS_ST_IDLE;
                end
            endcase
        end
        `AHS_ST_BACK: begin
            // reversed off a limit; wait for the switch to come on
            if (hs_rise) begin
                case (meth_q)
                    `AHS_M26: begin
                        state_d = `AHS_ST_FWD;
                        dir_d = `AHS_DIR_POS;
                        spd_d = `AHS_SPD_SECOND;
                    end
                    `AHS_M27: begin
                        state_d = `AHS_ST_FWD;
                        spd_d = `AHS_SPD_SECOND;
                    end
                    `AHS_M28: begin
                        state_d = `AHS_ST_BACK;
                    end
                    default: begin
                        state_d = `AHS_ST_FWD;
                        dir_d = `AHS_DIR_NEG;
                        spd_d = `AHS_SPD_SECOND;
                    end
                endcase
            end else if (hs_fall && meth_q == `AHS_M28) begin
                state_d = `AHS_ST_FWD;
                dir_d = `AHS_DIR_NEG;
            end
        end
        `AHS_ST_FWD: begin
            // final leg: 28 and 29 latch on rise, others on fall
            if ((meth_q == `AHS_M28 || meth_q == `AHS_M29) ? hs_rise : hs_fall) begin
                latch_now = 1'b1;
            end
        end
        default: begin
            state_d = `AHS_ST_IDLE;
        end
    endcase
    if (latch_now) begin
        state_d = `AHS_ST_IDLE;
        mv_d = 1'b0;
    end
end

always @(posedge core_clk_i) begin
    if (reset_i) begin
        state_q <= `AHS_ST_IDLE;
        meth_q <= {`AHS_METHOD_W{1'b0}};
        move_o <= 1'b0;
        dir_o <= `AHS_DIR_POS;
        speed_o <= `AHS_SPD_FIRST;
        home_pos_o <= {`AHS_POS_W{1'b0}};
        busy_o <= 1'b0;
        done_o <= 1'b0;
        error_o <= 1'b0;
    end else begin
        done_o <= 1'b0;
        if (state_q == `AHS_ST_IDLE) begin
            if (homing_request_i) begin
                meth_q <= method_i;
                error_o <= 1'b0;
                case (method_i)
                    `AHS_M26: begin
                        state_q <= `AHS_ST_SEEK;
                        move_o <= 1'b1;
                        busy_o <= 1'b1;
                        dir_o <= `AHS_DIR_POS;
                        speed_o <= hs_lvl;
                    end
                    `AHS_M27, `AHS_M28: begin
                        state_q <= `AHS_ST_SEEK;
                        move_o <= 1'b1;
                        busy_o <= 1'b1;
                        // on: positive second speed; off: negative first
                        dir_o <= hs_lvl;
                        speed_o <= hs_lvl;
                    end
                    `AHS_M29, `AHS_M30: begin
                        state_q <= `AHS_ST_SEEK;
                        move_o <= 1'b1;
                        busy_o <= 1'b1;
                        dir_o <= `AHS_DIR_NEG;
                        speed_o <= hs_lvl;
                    end
                    `AHS_M33, `AHS_M34: begin
                        state_q <= `AHS_ST_SEEK;
                        move_o <= 1'b1;
                        busy_o <= 1'b1;
                        // switches are not consulted in these methods
                        dir_o <= (method_i == `AHS_M34);
                        speed_o <= `AHS_SPD_SECOND;
                    end
                    `AHS_M35: begin
                        home_pos_o <= axis_pos_i;
                        done_o <= 1'b1;
                    end
                    default: begin
                        // 31, 32 and unsupported codes never move
                        error_o <= 1'b1;
                    end
                endcase
            end
        end else begin
            state_q <= state_d;
            move_o <= mv_d;
            dir_o <= dir_d;
            speed_o <= spd_d;
            if (latch_now) begin
                home_pos_o <= axis_pos_i;
                done_o <= 1'b1;
                busy_o <= 1'b0;
            end else if (state_d == `AHS_ST_IDLE) begin
                move_o <= 1'b0;
                busy_o <= 1'b0;
                error_o <= 1'b1;
            end
        end
    end
end

endmodule // ahs_homing

`default_nettype wire

// ===== src/ahs_regs.vh
// constants for the axis homing sequencer, methods 26 to 35
`ifndef AHS_REGS_VH
`define AHS_REGS_VH

`define AHS_POS_W 32
`define AHS_METHOD_W 6

// homing method codes
`define AHS_M26 6'h1A
`define AHS_M27 6'h1B
`define AHS_M28 6'h1C
`define AHS_M29 6'h1D
`define AHS_M30 6'h1E
`define AHS_M31 6'h1F
`define AHS_M32 6'h20
`define AHS_M33 6'h21
`define AHS_M34 6'h22
`define AHS_M35 6'h23

// direction and speed phase encodings
`define AHS_DIR_POS 1'b1
`define AHS_DIR_NEG 1'b0
`define AHS_SPD_FIRST 1'b0
`define AHS_SPD_SECOND 1'b1

// sequencer states
`define AHS_ST_IDLE 3'h0
`define AHS_ST_SEEK 3'h1
`define AHS_ST_BACK 3'h2
`define AHS_ST_FWD 3'h3
`define AHS_ST_FIN 3'h4
`define AHS_ST_W 3

`endif

// ===== src/ahs_sync.v
// two flip-flop synchroniser with edge detect on the settled value
`timescale 1ns/1ps
`default_nettype none

module ahs_sync (
    // clock and reset
    input wire core_clk_i,
    input wire reset_i,
    // raw pin and conditioned outputs
    input wire pin_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

reg meta_q;
reg sync_q;
reg prev_q;

// only sync_q reads meta_q
always @(posedge core_clk_i) begin
    if (reset_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        prev_q <= 1'b0;
    end else begin
        meta_q <= pin_i;
        sync_q <= meta_q;
        prev_q <= sync_q;
    end
end

assign level_o = sync_q;
assign rise_o = sync_q & ~prev_q;
assign fall_o = ~sync_q & prev_q;

endmodule // ahs_sync

`default_nettype wire

// ===== tb/ahs_homing_checker.sv
// port-level assertions for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ahs_regs.vh"
module ahs_homing_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // request and inputs
    input wire logic homing_request_i,
    input wire logic [`AHS_METHOD_W-1:0] method_i,
    input wire logic [`AHS_POS_W-1:0] axis_pos_i,
    input wire logic home_sw_i,
    input wire logic pos_limit_i,
    input wire logic neg_limit_i,
    input wire logic index_i,
    // outputs
    input wire logic move_o,
    input wire logic dir_o,
    input wire logic speed_o,
    input wire logic [`AHS_POS_W-1:0] home_pos_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic error_o
);
    logic [`AHS_METHOD_W-1:0] m_q;
    wire logic acc = homing_request_i && !busy_o;
    always @(posedge core_clk_i) begin
        if (reset_i) m_q <= 6'h00;
        else if (acc) m_q <= method_i;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    property p_done_pulse; done_o |=> !done_o; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    property p_done_stop; done_o |-> !move_o && !busy_o; endproperty
    a_done_stop: assert property (p_done_stop) else $error("motion at done");
    property p_move_busy; move_o |-> busy_o; endproperty
    a_move_busy: assert property (p_move_busy) else $error("move while idle");
    property p_start34;
        acc && method_i == `AHS_M34 |=> move_o && dir_o && speed_o && busy_o;
    endproperty
    a_start34: assert property (p_start34) else $error("index positive start");
    property p_start33;
        acc && method_i == `AHS_M33 |=> move_o && !dir_o && speed_o && busy_o;
    endproperty
    a_start33: assert property (p_start33) else $error("index negative start");
    property p_now35;
        acc && method_i == `AHS_M35 |=> done_o && !move_o && home_pos_o == $past(axis_pos_i);
    endproperty
    a_now35: assert property (p_now35) else $error("present position latch");
    property p_resv;
        acc && (method_i == `AHS_M31 || method_i == `AHS_M32) |=> error_o && !move_o && !busy_o;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved code moved");
    property p_err_hold; error_o && !acc |=> error_o; endproperty
    a_err_hold: assert property (p_err_hold) else $error("error dropped early");
    property p_index;
        busy_o && (m_q == `AHS_M33 || m_q == `AHS_M34) && $rose(index_i) |-> ##[1:4] done_o;
    endproperty
    a_index: assert property (p_index) else $error("index not latched");
endmodule // ahs_homing_checker

bind ahs_homing ahs_homing_checker u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .homing_request_i(homing_request_i), .method_i(method_i), .axis_pos_i(axis_pos_i),
    .home_sw_i(home_sw_i), .pos_limit_i(pos_limit_i), .neg_limit_i(neg_limit_i),
    .index_i(index_i), .move_o(move_o), .dir_o(dir_o), .speed_o(speed_o),
    .home_pos_o(home_pos_o), .busy_o(busy_o), .done_o(done_o), .error_o(error_o));
`default_nettype wire

// ===== tb/ahs_axis_model.sv
// axis drive, switches and encoder index seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module ahs_axis_model #(
    parameter int HLO = 100,
    parameter int HHI = 110,
    parameter int PLIM = 130,
    parameter int NLIM = 80
) (
    // clock and preset
    input wire logic core_clk_i,
    input wire logic load_i,
    input wire logic [31:0] load_val_i,
    // motion command
    input wire logic move_i,
    input wire logic dir_i,
    // position and sensors
    output logic [31:0] axis_pos_o,
    output wire logic home_sw_o,
    output wire logic pos_limit_o,
    output wire logic neg_limit_o,
    output wire logic index_o
);
    // one step per 8 cycles, so a latch 3 cycles late still sees the edge position
    logic [2:0] step_q = 3'h0;
    initial axis_pos_o = 32'h0000_0000;
    always @(posedge core_clk_i) begin
        step_q <= step_q + 3'h1;
        if (load_i) axis_pos_o <= load_val_i;
        else if (move_i && step_q == 3'h7) axis_pos_o <= dir_i ? axis_pos_o + 1 : axis_pos_o - 1;
    end
    assign home_sw_o = int'(axis_pos_o) >= HLO && int'(axis_pos_o) <= HHI;
    assign pos_limit_o = int'(axis_pos_o) >= PLIM;
    assign neg_limit_o = int'(axis_pos_o) <= NLIM;
    assign index_o = axis_pos_o[3:0] == 4'h0;
endmodule // ahs_axis_model
`default_nettype wire

// ===== tb/ahs_homing_bench.sv
// self-checking bench for the homing sequencer with an axis model
`timescale 1ns/1ps
`default_nettype none
`include "ahs_regs.vh"
module ahs_homing_bench;
    localparam int HLO = 100, HHI = 110;
    logic core_clk_i = 1'b0, reset_i = 1'b1, homing_request_i = 1'b0, load = 1'b0;
    logic [5:0] method_i = 6'h00;
    logic [31:0] load_val = 32'h0000_0000;
    wire logic [31:0] axis_pos, home_pos;
    wire home_sw, pos_lim, neg_lim, index, move, dir, speed, busy, done, error;
    int n_fail = 0, tests_run = 0, i;
    int exp_q[$];
    initial forever #12.5 core_clk_i = ~core_clk_i;
    ahs_homing dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .homing_request_i(homing_request_i), .method_i(method_i), .axis_pos_i(axis_pos),
        .home_sw_i(home_sw), .pos_limit_i(pos_lim), .neg_limit_i(neg_lim), .index_i(index),
        .move_o(move), .dir_o(dir), .speed_o(speed), .home_pos_o(home_pos),
        .busy_o(busy), .done_o(done), .error_o(error));
    ahs_axis_model #(.HLO(HLO), .HHI(HHI)) axis (.core_clk_i(core_clk_i), .load_i(load),
        .load_val_i(load_val), .move_i(move), .dir_i(dir), .axis_pos_o(axis_pos),
        .home_sw_o(home_sw), .pos_limit_o(pos_lim), .neg_limit_o(neg_lim), .index_o(index));
    // ----
    // reference and checks
    // ----
    function automatic int expect_home(int m, int s);
        case (m)
            26, 27: return HHI + 1;
            28: return HHI;
            29: return HLO;
            30: return HLO - 1;
            33: return s - s % 16;
            34: return s - s % 16 + 16;
            35: return s;
            default: return -1;
        endcase
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // first command after a request, packed as {move, dir, speed}
    function automatic logic [2:0] expect_start(int m, int s);
        logic on;
        on = s >= HLO && s <= HHI;
        case (m)
            26: return {1'b1, 1'b1, on};
            27, 28: return {1'b1, on, on};
            33: return 3'h5;
            34: return 3'h7;
            default: return {1'b1, 1'b0, on};
        endcase
    endfunction
    // start below, on, or above the home switch, clear of both limits
    function automatic int region_start(int r);
        case (r)
            0: return 84 + $urandom % 14;
            1: return HLO + $urandom % 11;
            default: return 112 + $urandom % 15;
        endcase
    endfunction
    task automatic start(input int m, input int s);
        @(posedge core_clk_i);
        load <= 1'b1;
        load_val <= s;
        @(posedge core_clk_i);
        load <= 1'b0;
        // let the synchronisers settle on the new position
        repeat (5) @(posedge core_clk_i);
        method_i <= m[5:0];
        homing_request_i <= 1'b1;
        @(posedge core_clk_i);
        homing_request_i <= 1'b0;
        #1;
    endtask
    task automatic run(input int m, input int s);
        int e, k;
        logic [2:0] st;
        exp_q.push_back(expect_home(m, s));
        st = expect_start(m, s);
        start(m, s);
        e = exp_q.pop_front();
        if (m >= 26 && m <= 30)
            check({move, dir, speed}, st);
        if (m == 33 || m == 34)
            check({move, dir, speed}, st);
        for (k = 0; k < 3000; k++) begin
            if (done === 1'b1 || error === 1'b1) break;
            @(posedge core_clk_i);
            #1;
        end
        check(k < 3000, 1'b1);
        if (e < 0) check(error, 1'b1);
        else if (m < 31) check(home_pos, e[31:0]);
        else check(home_pos, e[31:0]);
        check(move, 1'b0);
        check(busy, 1'b0);
        $display("test method %0d start %0d ended", m, s);
    endtask
    // reset in the middle of a homing run must drop all motion
    task automatic abort_run(input int m, input int s);
        start(m, s);
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b1;
        #1;
        check(busy, 1'b1);
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        #1;
        check({move, busy, dir, speed, done, error}, 6'h08);
        @(posedge core_clk_i);
        #1;
        check({move, busy, done}, 3'h0);
        $display("test reset during method %0d ended", m);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----
    // sequence
    // ----
    initial begin
        void'($urandom(32'h3c0e7091));
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        // every switch method from each side of the switch, limit paths included
        for (i = 0; i < 15; i++) begin
            run(26 + i / 3, region_start(i % 3));
        end
        for (i = 0; i < 4; i++) begin
            run(33 + i % 2, 16 * (5 + i) + 1 + $urandom % 15);
        end
        run(31, 90);
        run(32, 95);
        run($urandom % 26, 90);
        abort_run(34, 97 + $urandom % 10);
        repeat (2) run(35, $urandom % 1000);
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_fail++;
        wrap_up;
    end
endmodule // ahs_homing_bench
`default_nettype wire
